/* design/tis_pkg.sv */
// Package: register map, field positions, reset values and timing constants
package tis_pkg;
   localparam int ADDR_W = 4;
   // Register byte offsets
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_TEMP = 4'h4;
   localparam logic [ADDR_W-1:0] ADDR_TIME = 4'h8;
   localparam logic [ADDR_W-1:0] ADDR_STAT = 4'hc;
   // Reset values
   localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
   localparam logic [31:0] CTRL_MASK = 32'h0000_0fff;
   localparam logic [31:0] TEMP_RST  = 32'h0032_3237;
   localparam logic [31:0] TIME_RST  = 32'h0014_1e1e;
   // Control bit positions
   localparam int B_OP     = 0;
   localparam int B_MODE   = 1;
   localparam int B_HTR_ON = 3;
   localparam int B_EXT    = 4;
   localparam int B_INTUSE = 5;
   localparam int B_BACKUP = 6;
   localparam int B_AFRZ   = 7;
   localparam int B_PURGE  = 8;
   localparam int B_ROOMTH = 9;
   localparam int B_WATERTH = 10;
   localparam int B_ROOMHTR = 11;
   // Temperature and timer field positions (8 bits each)
   localparam int F_TANK   = 0;
   localparam int F_SET    = 8;
   localparam int F_LIMIT  = 16;
   localparam int F_REHEAT = 24;
   localparam int F_TANKIV = 0;
   localparam int F_ROOMIV = 8;
   localparam int F_EXTDLY = 16;
   // Operating modes
   typedef enum logic [1:0] {MODE_TANK = 2'h0, MODE_HEAT = 2'h1, MODE_COOL = 2'h2} tis_mode_t;
   // Interval states, one-hot
   typedef enum logic [2:0] {ST_IDLE = 3'h1, ST_TANK = 3'h2, ST_ROOM = 3'h4} tis_state_t;
   // Timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int SEC_NS        = 1000000000;
   localparam int SEC_TICKS     = SEC_NS / CLK_PERIOD_NS;
   localparam int MIN_S         = 60;
   localparam int HOLD_S        = 20;
   localparam int SET_S         = 15;
   localparam int OFF_DLY_S     = 15;
   localparam int MASK_S        = 70;
   localparam int FLOW_LOW_S    = 60;
   localparam int RESTART_MIN   = 3;
   localparam int INT_GAP_MIN   = 20;
   localparam int SHORT_MIN     = 30;
   localparam int SHORT_LIMIT   = 3;
endpackage

/* design/tis_top.sv */
// Tank interval scheduler: tank thermo, interval FSM, heaters, pump, AXI4-Lite registers
// Summary of operation
// - Separate-heater setup: tank thermo-off stops pump, compressor, room heater; valve to room.
// - Separate-heater setup: tank on condition starts pump and compressor, room heater off.
// - After water thermo stop, tank over water set 20 s: compressor off, pump, heater on.
// - Tank over set plus 1 for 20 s stops everything, valve to room.
// - Tank below water set plus reheat runs pump, compressor, valve to tank.
// - Internal heater serves tank only if chosen, switched on and backup enabled.
// - Internal heater on: below set, compressor thermo off, 20 min gap, set to use.
// - Internal heater off: above set 15 s, compressor on, mode change, operation off.
// - External heater acts only with tank heater on and external option chosen.
// - Combined modes alternate room and tank intervals, tank first, valve follows.
// - After thermo-off handover, room ends once tank drops below thermo-on.
// - Three short room intervals hold room until timer or room thermo off, tank low.
// - After tank timer handover, same room hold applies.
// - Tank interval ends on thermo-off or timer; tank-only control meanwhile.
// - Thermo-on threshold uses set temperature with internal use, else water set.
// - Room heater held off in cool room intervals, normal in heat ones.
// - Internal heater off in room intervals, on after compressor thermo-off in tank.
// - External heater off with delay timer restart on tank entry, cleared in room.
// - In combined modes the pump runs if room or tank thermo is on.
// - Pump starts at once, 70 s mask; outdoor fault inside the mask stops compressor for 3 min.
// - After mask, low flow 60 s latches pump and compressor off, blinks, flags.
// - Pump off requests wait 15 s except in anti-freeze deice or air purge.
// - Tank water set is the lower of tank set and tank limit.
//
// Chosen here: the address map and register access over AXI4-Lite.

////////////////////////////////////////////////////////////////////////////////
// Seconds dwell counter, saturating at its limit
module tis_dwell #(
   parameter int W = 16
) (
   input  wire logic         core_clk,
   input  wire logic         rst_b,
   input  wire logic         tick,
   input  wire logic         run,
   input  wire logic [W-1:0] limit,
   output logic              done
);
   logic [W-1:0] cnt_q;

   // Count while run holds, clear as soon as it lapses
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
         cnt_q <= '0;
      else if (!run)
         cnt_q <= '0;
      else if (tick && cnt_q < limit)
         cnt_q <= cnt_q + W'(1);
   end

   assign done = run && (cnt_q >= limit);
endmodule

////////////////////////////////////////////////////////////////////////////////
module tis_top #(
   parameter int TICK_CYCLES = tis_pkg::SEC_TICKS
) (
   input  wire logic                      core_clk,
   input  wire logic                      rst_b,
   input  wire logic                      awvalid,
   output logic                           awready,
   input  wire logic [tis_pkg::ADDR_W-1:0] awaddr,
   input  wire logic                      wvalid,
   output logic                           wready,
   input  wire logic [31:0]               wdata,
   input  wire logic [3:0]                wstrb,
   output logic                           bvalid,
   input  wire logic                      bready,
   output logic [1:0]                     bresp,
   input  wire logic                      arvalid,
   output logic                           arready,
   input  wire logic [tis_pkg::ADDR_W-1:0] araddr,
   output logic                           rvalid,
   input  wire logic                      rready,
   output logic [31:0]                    rdata,
   output logic [1:0]                     rresp,
   input  wire logic                      flowOkPin,
   input  wire logic                      outdoorFaultPin,
   output logic                           hpRun,
   output logic                           waterPump,
   output logic                           roomHeater,
   output logic                           intHeater,
   output logic                           extHeater,
   output logic                           valveTank,
   output logic                           opLed,
   output logic                           flowError
);
   import tis_pkg::*;

   logic [31:0] ctrl_q, temp_q, time_q;
   logic        awHave_q, wHave_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic [ADDR_W-1:0] awAddr_q;
   logic [31:0] wData_q, rdata_q;
   logic [3:0]  wStrb_q;
   logic [1:0]  bresp_q, rresp_q;
   logic [23:0] tickCnt_q;
   logic        tick, flowS1_q, flowOk_q, faultS1_q, fault_q, maskDone;
   logic        hpRun_q, waterPump_q, roomHeater_q, intHeater_q, extHeater_q, valveTank_q;
   logic        opLed_q, flowErr_q, tankThermo_q, hpTankOff_q, causeTimer_q, restartBusy_q;
   logic [1:0]  shortCnt_q, modePrev_q;
   tis_state_t  state_q;

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write channel
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
         if (be[i])
            r[8*i +: 8] = nw[8*i +: 8];
      return r;
   endfunction

   // Address and data taken in either order, response after both
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         awHave_q  <= 1'b0;
         wHave_q   <= 1'b0;
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
         bvalid_q  <= 1'b0;
         bresp_q   <= 2'h0;
         awAddr_q  <= '0;
         wData_q   <= 32'h0;
         wStrb_q   <= 4'h0;
      end
      else
      begin
         if (awvalid && awready_q)
         begin
            awHave_q  <= 1'b1;
            awready_q <= 1'b0;
            awAddr_q  <= awaddr;
         end
         if (wvalid && wready_q)
         begin
            wHave_q  <= 1'b1;
            wready_q <= 1'b0;
            wData_q  <= wdata;
            wStrb_q  <= wstrb;
         end
         if (awHave_q && wHave_q && !bvalid_q)
         begin
            awHave_q <= 1'b0;
            wHave_q  <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q  <= (awAddr_q[1:0] != 2'h0 || awAddr_q > ADDR_STAT) ? 2'h2 : 2'h0;
         end
         if (bvalid_q && bready)
         begin
            bvalid_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
         end
      end
   end

   // Register storage; status is read-only
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ctrl_q <= CTRL_RST;
         temp_q <= TEMP_RST;
         time_q <= TIME_RST;
      end
      else if (awHave_q && wHave_q && !bvalid_q)
      begin
         case (awAddr_q)
            ADDR_CTRL: ctrl_q <= merge(ctrl_q, wData_q, wStrb_q) & CTRL_MASK;
            ADDR_TEMP: temp_q <= merge(temp_q, wData_q, wStrb_q);
            ADDR_TIME: time_q <= merge(time_q, wData_q, wStrb_q);
            default: ;
         endcase
      end
   end

   // Read channel, data one cycle after address
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0;
         rresp_q   <= 2'h0;
      end
      else if (arvalid && arready_q)
      begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b1;
         rresp_q   <= 2'h0;
         case (araddr)
            ADDR_CTRL: rdata_q <= ctrl_q;
            ADDR_TEMP: rdata_q <= temp_q;
            ADDR_TIME: rdata_q <= time_q;
            ADDR_STAT: rdata_q <= {17'h0, flowErr_q, maskDone, restartBusy_q, shortCnt_q,
                                   state_q, tankThermo_q, hpTankOff_q, extHeater_q,
                                   intHeater_q, roomHeater_q, waterPump_q, hpRun_q};
            default:
            begin
               rdata_q <= 32'h0;
               rresp_q <= 2'h2;
            end
         endcase
      end
      else if (rvalid_q && rready)
      begin
         rvalid_q  <= 1'b0;
         arready_q <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and one-second tick
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         flowS1_q  <= 1'b0;
         flowOk_q  <= 1'b0;
         faultS1_q <= 1'b0;
         fault_q   <= 1'b0;
         tickCnt_q <= 24'h0;
      end
      else
      begin
         flowS1_q  <= flowOkPin;
         flowOk_q  <= flowS1_q;
         faultS1_q <= outdoorFaultPin;
         fault_q   <= faultS1_q;
         tickCnt_q <= tick ? 24'h0 : tickCnt_q + 24'h1;
      end
   end
   assign tick = (tickCnt_q == 24'(TICK_CYCLES - 1));

   ////////////////////////////////////////////////////////////////////////////
   // Decoded controls and thresholds
   logic       opOn, combined, coolMode, extSel, htrOn, caseInt, roomTh, tankPhase, inRoom;
   logic [7:0] tankT, tankSet, tankWs;
   logic signed [9:0] thermoOnThr;
   logic       belowOn, belowSet, modeChg;

   assign opOn     = ctrl_q[B_OP];
   assign combined = ctrl_q[B_MODE +: 2] == MODE_HEAT || ctrl_q[B_MODE +: 2] == MODE_COOL;
   assign coolMode = ctrl_q[B_MODE +: 2] == MODE_COOL;
   assign extSel   = ctrl_q[B_EXT];
   assign htrOn    = ctrl_q[B_HTR_ON];
   assign caseInt  = !extSel && htrOn;
   assign roomTh   = ctrl_q[B_ROOMTH];
   assign inRoom   = combined && state_q == ST_ROOM;
   assign tankPhase = !combined || state_q == ST_TANK;
   assign modeChg  = ctrl_q[B_MODE +: 2] != modePrev_q;
   assign tankT    = temp_q[F_TANK +: 8];
   assign tankSet  = temp_q[F_SET +: 8];
   // Water set is the lower of set and limit
   assign tankWs   = (temp_q[F_LIMIT +: 8] < tankSet) ? temp_q[F_LIMIT +: 8] : tankSet;
   // Thermo-on threshold with signed reheat offset
   assign thermoOnThr = $signed({2'b00, ctrl_q[B_INTUSE] ? tankSet : tankWs})
                        + $signed({{2{temp_q[F_REHEAT + 7]}}, temp_q[F_REHEAT +: 8]});
   assign belowOn  = $signed({2'b00, tankT}) < thermoOnThr;
   assign belowSet = tankT < tankSet;

   ////////////////////////////////////////////////////////////////////////////
   // Dwell timers
   logic ws20Done, over1Done, set15Done, tankIvDone, roomIvDone, shortDone, extDlyDone;
   logic flowLowDone, restartDone, offDone, intGapDone, pumpReq, immediate;

   tis_dwell u_ws20 (.core_clk(core_clk), .rst_b(rst_b), .tick(tick),
      .run(ctrl_q[B_WATERTH] && tankT > tankWs), .limit(16'(HOLD_S)), .done(ws20Done));
   tis_dwell u_over1 (.core_clk(core_clk), .rst_b(rst_b), .tick(tick),
      .run({1'b0, tankT} > {1'b0, tankSet} + 9'h1), .limit(16'(HOLD_S)), .done(over1Done));
   tis_dwell u_set15 (.core_clk(core_clk), .rst_b(rst_b), .tick(tick),
      .run(tankT > tankSet), .limit(16'(SET_S)), .done(set15Done));
   tis_dwell u_tankiv (.core_clk(core_clk), .rst_b(rst_b), .tick(tick),
      .run(combined && state_q == ST_TANK),
      .limit(16'(time_q[F_TANKIV +: 8] * MIN_S)), .done(tankIvDone));
   tis_dwell u_roomiv (.core_clk(core_clk), .rst_b(rst_b), .tick(tick), .run(inRoom),
      .limit(16'(time_q[F_ROOMIV +: 8] * MIN_S)), .done(roomIvDone));
   tis_dwell u_short (.core_clk(core_clk), .rst_b(rst_b), .tick(tick), .run(inRoom),
      .limit(16'(SHORT_MIN * MIN_S)), .done(shortDone));
   tis_dwell u_extdly (.core_clk(core_clk), .rst_b(rst_b), .tick(tick),
      .run(combined ? state_q == ST_TANK : tankThermo_q),
      .limit(16'(time_q[F_EXTDLY +: 8] * MIN_S)), .done(extDlyDone));
   tis_dwell u_mask (.core_clk(core_clk), .rst_b(rst_b), .tick(tick), .run(opOn),
      .limit(16'(MASK_S)), .done(maskDone));
   tis_dwell u_flow (.core_clk(core_clk), .rst_b(rst_b), .tick(tick),
      .run(maskDone && waterPump_q && !flowOk_q), .limit(16'(FLOW_LOW_S)),
      .done(flowLowDone));
   tis_dwell u_restart (.core_clk(core_clk), .rst_b(rst_b), .tick(tick), .run(restartBusy_q),
      .limit(16'(RESTART_MIN * MIN_S)), .done(restartDone));
   tis_dwell u_offdly (.core_clk(core_clk), .rst_b(rst_b), .tick(tick),
      .run(waterPump_q && !pumpReq), .limit(16'(OFF_DLY_S)), .done(offDone));
   tis_dwell u_intgap (.core_clk(core_clk), .rst_b(rst_b), .tick(tick), .run(!intHeater_q),
      .limit(16'(INT_GAP_MIN * MIN_S)), .done(intGapDone));

   ////////////////////////////////////////////////////////////////////////////
   // Tank thermo and water-thermo compressor hold
   logic offCond;
   assign offCond = caseInt ? set15Done : over1Done;

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         tankThermo_q <= 1'b0;
         hpTankOff_q  <= 1'b0;
         modePrev_q   <= 2'h0;
      end
      else
      begin
         modePrev_q <= ctrl_q[B_MODE +: 2];
         if (!opOn || offCond)
         begin
            tankThermo_q <= 1'b0;
            hpTankOff_q  <= 1'b0;
         end
         else if (belowOn)
         begin
            tankThermo_q <= 1'b1;
            hpTankOff_q  <= 1'b0;
         end
         else if (!caseInt && ws20Done)
            hpTankOff_q <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Room / tank interval state machine
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_q      <= ST_IDLE;
         causeTimer_q <= 1'b0;
         shortCnt_q   <= 2'h0;
      end
      else if (!opOn || !combined)
      begin
         state_q    <= ST_IDLE;
         shortCnt_q <= 2'h0;
      end
      else
      begin
         case (state_q)
            ST_IDLE: state_q <= ST_TANK;
            ST_TANK:
               if (!tankThermo_q || tankIvDone)
               begin
                  state_q      <= ST_ROOM;
                  causeTimer_q <= tankThermo_q;
               end
            ST_ROOM:
               if (belowOn && (!(causeTimer_q || shortCnt_q >= 2'(SHORT_LIMIT))
                               || roomIvDone || !roomTh))
               begin
                  state_q    <= ST_TANK;
                  shortCnt_q <= shortDone ? 2'h0
                                : (shortCnt_q == 2'(SHORT_LIMIT) ? shortCnt_q : shortCnt_q + 2'h1);
               end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Start-up mask, outdoor fault restart delay, flow error latch
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         restartBusy_q <= 1'b0;
         flowErr_q     <= 1'b0;
         opLed_q       <= 1'b0;
      end
      else
      begin
         if (opOn && !maskDone && fault_q)
            restartBusy_q <= 1'b1;
         else if (restartDone)
            restartBusy_q <= 1'b0;
         if (flowLowDone)
            flowErr_q <= 1'b1;
         if (flowErr_q)
            opLed_q <= tick ? !opLed_q : opLed_q;
         else
            opLed_q <= opOn;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pump, compressor, valve and heater outputs
   logic hpReq, intAllowed;
   assign hpReq = tankPhase ? (tankThermo_q && !hpTankOff_q && !ctrl_q[B_WATERTH])
                            : roomTh;
   assign pumpReq = opOn && !flowErr_q
                    && (!maskDone || (combined ? (roomTh || tankThermo_q) : tankThermo_q));
   assign immediate = ctrl_q[B_AFRZ] || ctrl_q[B_PURGE];
   assign intAllowed = opOn && !extSel && htrOn && ctrl_q[B_BACKUP] && ctrl_q[B_INTUSE]
                       && !inRoom;

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         waterPump_q  <= 1'b0;
         hpRun_q      <= 1'b0;
         valveTank_q  <= 1'b0;
         roomHeater_q <= 1'b0;
         intHeater_q  <= 1'b0;
         extHeater_q  <= 1'b0;
      end
      else
      begin
         if (flowErr_q)
            waterPump_q <= 1'b0;
         else if (pumpReq)
            waterPump_q <= 1'b1;
         else if (immediate || offDone)
            waterPump_q <= 1'b0;
         // Compressor may run inside the start-up mask; only a fault holds it off
         hpRun_q <= opOn && !flowErr_q && !restartBusy_q && hpReq;
         valveTank_q <= opOn && (combined ? state_q == ST_TANK : tankThermo_q);
         if (tankPhase)
            roomHeater_q <= opOn && !flowErr_q && hpTankOff_q && tankThermo_q;
         else
            roomHeater_q <= opOn && !flowErr_q && !coolMode && ctrl_q[B_ROOMHTR];
         if (!intAllowed || set15Done || hpReq || modeChg)
            intHeater_q <= 1'b0;
         else if (belowSet && intGapDone)
            intHeater_q <= 1'b1;
         extHeater_q <= opOn && extSel && htrOn && belowSet
                        && (inRoom || extDlyDone);
      end
   end

   assign awready    = awready_q;
   assign wready     = wready_q;
   assign bvalid     = bvalid_q;
   assign bresp      = bresp_q;
   assign arready    = arready_q;
   assign rvalid     = rvalid_q;
   assign rdata      = rdata_q;
   assign rresp      = rresp_q;
   assign hpRun      = hpRun_q;
   assign waterPump  = waterPump_q;
   assign roomHeater = roomHeater_q;
   assign intHeater  = intHeater_q;
   assign extHeater  = extHeater_q;
   assign valveTank  = valveTank_q;
   assign opLed      = opLed_q;
   assign flowError  = flowErr_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   flow_latch_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      flowErr_q |=> flowErr_q && !waterPump_q && !hpRun_q)
      else $error("flow error latch released or outputs left on");
   pump_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      waterPump_q && !pumpReq && !immediate && !offDone && !flowErr_q |=> waterPump_q)
      else $error("pump stopped before off delay");
   pump_fast_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      waterPump_q && !pumpReq && immediate |=> !waterPump_q)
      else $error("pump stop delayed during deice or purge");
   tank_first_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      state_q == ST_IDLE && opOn && combined |=> state_q == ST_TANK ##1 valveTank_q || !opOn)
      else $error("combined mode did not begin with tank interval");
   cool_heater_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      inRoom && coolMode |=> !roomHeater_q)
      else $error("room heater on in cool room interval");
   int_room_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      inRoom |=> !intHeater_q)
      else $error("internal heater on in room interval");
   thermo_off_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      offCond |=> !tankThermo_q ##1 !hpRun_q || !combined)
      else $error("tank thermo not ended at off condition");
   restart_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      restartBusy_q |=> !hpRun_q)
      else $error("compressor ran during restart delay");
endmodule

/* sim/test_tis_top.sv */
// Testbench for the tank interval scheduler
module test_tis_top;
   import tis_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk, rst_b, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, lowFlow, fault, flowOkPin, outdoorFaultPin;
   logic hpRun, waterPump, roomHeater, intHeater, extHeater, valveTank, opLed, flowError;
   logic [3:0]  awaddr, araddr, wstrb;
   logic [31:0] wdata, rdata, rd;
   logic [1:0]  bresp, rresp;
   int          n_fail, n_checks, cyc;
   tis_top #(.TICK_CYCLES(10)) u_dut (
      .core_clk        (core_clk),
      .rst_b           (rst_b),
      .awvalid         (awvalid),
      .awready         (awready),
      .awaddr          (awaddr),
      .wvalid          (wvalid),
      .wready          (wready),
      .wdata           (wdata),
      .wstrb           (wstrb),
      .bvalid          (bvalid),
      .bready          (bready),
      .bresp           (bresp),
      .arvalid         (arvalid),
      .arready         (arready),
      .araddr          (araddr),
      .rvalid          (rvalid),
      .rready          (rready),
      .rdata           (rdata),
      .rresp           (rresp),
      .flowOkPin       (flowOkPin),
      .outdoorFaultPin (outdoorFaultPin),
      .hpRun           (hpRun),
      .waterPump       (waterPump),
      .roomHeater      (roomHeater),
      .intHeater       (intHeater),
      .extHeater       (extHeater),
      .valveTank       (valveTank),
      .opLed           (opLed),
      .flowError       (flowError)
   );
   tis_plant u_plant (.pump(waterPump), .lowFlow(lowFlow), .fault(fault),
      .flowOkPin(flowOkPin), .outdoorFaultPin(outdoorFaultPin));
   ////////////////////////////////////////////////////////////////////////////
   // Clock and hang guard
   initial
   begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_fail++;
         summarize();
      end
   end
   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // AXI4-Lite write and read
   // One edge passes after each handshake so back-to-back calls never re-drive in one step
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do
      begin
         @(posedge core_clk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rdr(input logic [3:0] a);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do
      begin
         @(posedge core_clk);
         if (arready)
            arvalid <= 1'b0;
      end while (!rvalid);
      rd = rdata;
      rready <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic secs(input int s);
      repeat (s * 10) @(posedge core_clk);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      {awvalid, wvalid, bready, arvalid, rready, lowFlow, fault} <= '0;
      {awaddr, araddr, wdata} <= '0;
      wstrb <= 4'hf;
      rst_b <= 1'b0;
      repeat (6) @(posedge core_clk);
      rst_b <= 1'b1;
      rdr(ADDR_TEMP);
      chk(rd, TEMP_RST);
      rdr(ADDR_TIME);
      chk(rd, TIME_RST);
      rdr(4'h2);
      chk({30'h0, rresp}, 32'h2);
      wr(ADDR_TEMP, 32'h0032_3228);
      wr(ADDR_CTRL, 32'h1);
      secs(5);
      chk({hpRun, waterPump, valveTank}, 3'h7);
      wr(ADDR_TEMP, 32'h0032_3234);
      secs(18);
      chk(hpRun, 1'b1);
      secs(4);
      chk({hpRun, roomHeater, valveTank}, 3'h0);
      secs(70);
      chk(waterPump, 1'b0);
      wr(ADDR_TEMP, 32'h0032_3228);
      wr(ADDR_CTRL, 32'h3);
      secs(3);
      chk({waterPump, valveTank}, 2'h3);
      rdr(ADDR_STAT);
      chk(rd[9:7], 3'h2);
      lowFlow <= 1'b1;
      secs(80);
      chk({flowError, hpRun, waterPump}, 3'h4);
      // Error blink: indicator toggles once a second
      rd[0] = opLed;
      secs(1);
      chk(opLed, !rd[0]);
      // Mid-run power reset is the only way out of the flow latch
      rst_b <= 1'b0;
      lowFlow <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_b <= 1'b1;
      // Heat+tank, external heater, one minute delay; outdoor fault inside the mask
      wr(ADDR_TEMP, 32'h0032_3228);
      wr(ADDR_TIME, 32'h0001_1e1e);
      wr(ADDR_CTRL, 32'h1b);
      secs(3);
      chk(flowError, 1'b0);
      chk(extHeater, 1'b0);
      fault <= 1'b1;
      secs(1);
      chk(hpRun, 1'b0);
      fault <= 1'b0;
      secs(60);
      chk(extHeater, 1'b1);
      secs(125);
      chk(hpRun, 1'b1);
      // Operation off during deice: pump stops without delay
      wr(ADDR_CTRL, 32'h80);
      secs(1);
      chk(waterPump, 1'b0);
      // Internal heater, compressor held off by water thermo
      wr(ADDR_CTRL, 32'h469);
      secs(5);
      chk(intHeater, 1'b0);
      secs(1020);
      chk(intHeater, 1'b1);
      wr(ADDR_CTRL, 32'h69);
      secs(1);
      chk(intHeater, 1'b0);
      summarize();
   end
endmodule

/* sim/tis_plant.sv */
// Far-side model: flow switch and outdoor unit
module tis_plant (
   input  wire logic pump,
   input  wire logic lowFlow,
   input  wire logic fault,
   output logic      flowOkPin,
   output logic      outdoorFaultPin
);
   timeunit 1ns;
   timeprecision 1ns;
   // Flow only when the pump runs and no blockage is commanded
   assign flowOkPin       = pump & ~lowFlow;
   assign outdoorFaultPin = fault;
endmodule
